/* dv/reload_timer_checker.sv */
// port-level assertion checker for the reload timer
`timescale 1ns/1ps
`include "timer_regs.vh"
module reload_timer_checker #(parameter PRESCALE_WIDTH = 11) (
    input wire clock, input wire rstn, input wire hsel,
    input wire [31:0] haddr, input wire [1:0] htrans, input wire hwrite,
    input wire [2:0] hsize, input wire [31:0] hwdata, input wire hready,
    input wire [31:0] hrdata, input wire hreadyout, input wire hresp,
    input wire timer_output_pin, input wire timer_pin_select,
    input wire chip_reset_request, input wire overflow_irq_flag
);
    reg rd_q;
    reg wr_q;
    reg [7:0] a_q;
    reg [2:0] om;
    reg [1:0] age;
    wire take = hsel && hready && htrans[1];
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // data-phase tracking and the output mode last written
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            a_q <= 8'h00;
            om <= 3'h0;
            age <= 2'h3;
        end else begin
            rd_q <= take && !hwrite;
            wr_q <= take && hwrite;
            a_q <= haddr[7:0];
            if (wr_q && a_q == `ADDR_TIMER_OUTPUT_MODE) begin
                om <= hwdata[2:0];
                age <= 2'h0;
            end else if (age != 2'h3) begin
                age <= age + 2'h1;
            end
        end
    end
    mode_reads_zero_a: assert property (
        rd_q && a_q == `ADDR_TIMER_MODE_PRIMARY |-> hrdata == 32'h0)
        else $error("mode register read not zero");
    out_mode_read_a: assert property (
        rd_q && a_q == `ADDR_TIMER_OUTPUT_MODE |-> hrdata == {29'h0, om})
        else $error("output mode readback wrong");
    count_nibble_a: assert property (
        rd_q && a_q[7:3] == 5'h07 |-> hrdata[31:4] == 28'h0)
        else $error("count read wider than a nibble");
    irq_sticky_a: assert property (
        overflow_irq_flag && !(wr_q && a_q == `ADDR_FLAGS && !hwdata[2])
        |=> overflow_irq_flag) else $error("overflow flag lost");
    wdog_pulse_a: assert property (chip_reset_request |=>
        !chip_reset_request) else $error("chip reset request too long");
    pin_select_a: assert property (age == 2'h3 |-> timer_pin_select ==
        (om == 3'h1 || om == 3'h2 || om == 3'h3 || om == 3'h7))
        else $error("pin select does not follow output mode");
    force_low_a: assert property (age == 2'h3 && om == `OUT_FORCE0 &&
        $changed(timer_output_pin) |-> !timer_output_pin)
        else $error("pin rose in force-low mode");
    force_high_a: assert property (age == 2'h3 && om == `OUT_FORCE1 &&
        $changed(timer_output_pin) |-> timer_output_pin)
        else $error("pin fell in force-high mode");
    reset_low_a: assert property ($rose(rstn) |->
        !timer_output_pin && !timer_pin_select) else $error("pin not low");
    cover property (chip_reset_request);
    cover property ($fell(overflow_irq_flag));
    cover property (om == `OUT_PWM && $fell(timer_output_pin));
endmodule // reload_timer_checker
bind reload_timer reload_timer_checker #(.PRESCALE_WIDTH(PRESCALE_WIDTH))
    chk_u (.*);

/* dv/tb_reload_timer.sv */
// register-level testbench for the reload timer
`timescale 1ns/1ps
`include "timer_regs.vh"
module tb_reload_timer;
    logic clock, rstn, hsel, hwrite, hreadyout, hresp, timer_output_pin;
    logic timer_pin_select, chip_reset_request, overflow_irq_flag;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int err_total, num_checks, n;
    int tick_tab[8] = '{2048, 1024, 512, 128, 32, 8, 4, 2};
    reload_timer dut_u (.*, .hready(hreadyout));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task summarize;
        if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task hang;
        err_total++;
        $display("ERROR %0t wait timed out", $time);
        summarize;
    endtask
    // one single ahb transfer, address phase then data phase
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        k = 0;
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'h2;
        do begin @(posedge clock); k++; end while (hreadyout !== 1'b1 && k < 20);
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge clock); k++; end while (hreadyout !== 1'b1 && k < 40);
        if (k >= 40) hang;
        rd = hrdata;
        chk(hresp, 0);
    endtask
    task wpin(output int c);
        logic p;
        p = timer_output_pin;
        c = 0;
        do begin @(negedge clock); c++; end
        while (timer_output_pin === p && c < 20000);
        if (c >= 20000) hang;
    endtask
    task load(input logic [7:0] v);
        xfer(`ADDR_RELOAD_LOW, 1'b1, {28'h0, v[3:0]});
        xfer(`ADDR_RELOAD_HIGH, 1'b1, {28'h0, v[7:4]});
    endtask
    task set_mode(input logic [3:0] m);
        xfer(`ADDR_TIMER_MODE_PRIMARY, 1'b1, {28'h0, m});
        repeat (3) @(posedge clock);
    endtask
    initial begin
        {rstn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        err_total = 0;
        num_checks = 0;
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        chk(timer_output_pin, 0);
        xfer(`ADDR_TIMER_OUTPUT_MODE, 1'b0, 0); chk(rd, 0);
        xfer(`ADDR_TIMER_MODE_PRIMARY, 1'b0, 0); chk(rd, 0);
        xfer(8'h44, 1'b0, 0); chk(rd, 0);
        xfer(`ADDR_RELOAD_LOW, 1'b1, 32'h5);
        xfer(`ADDR_RELOAD_HIGH, 1'b0, 0); chk(rd, 0);
        xfer(`ADDR_RELOAD_LOW, 1'b0, 0); chk(rd, 0);
        xfer(`ADDR_RELOAD_HIGH, 1'b1, 32'h3);
        xfer(`ADDR_RELOAD_HIGH, 1'b0, 0); chk(rd, 3);
        xfer(`ADDR_RELOAD_LOW, 1'b1, 32'h9);
        xfer(`ADDR_RELOAD_LOW, 1'b0, 0); chk(rd, 5);
        xfer(`ADDR_RELOAD_HIGH, 1'b1, 32'h7);
        xfer(`ADDR_RELOAD_HIGH, 1'b0, 0); chk(rd, 7);
        xfer(`ADDR_RELOAD_LOW, 1'b0, 0); chk(rd, 9);
        // toggle output: two ticks between overflows at every select code
        xfer(`ADDR_TIMER_OUTPUT_MODE, 1'b1, `OUT_TOGGLE);
        for (int s = 0; s < 8; s++) begin
            set_mode(4'h8 | s[3:0]);
            load(8'hFE);
            repeat (3) wpin(n);
            chk(n, 2 * tick_tab[s]);
        end
        set_mode(4'h7);
        load(8'hFE);
        repeat (3) wpin(n);
        chk(n, 512);
        set_mode(4'h0);
        load(8'h00);
        xfer(`ADDR_FLAGS, 1'b0, 0); chk(rd[2], 1);
        chk(overflow_irq_flag, 1);
        xfer(`ADDR_FLAGS, 1'b1, 0);
        xfer(`ADDR_FLAGS, 1'b0, 0); chk(rd[2], 0);
        chk(overflow_irq_flag, 0);
        set_mode(4'hF);
        load(8'hFE);
        xfer(`ADDR_TIMER_OUTPUT_MODE, 1'b1, `OUT_FORCE1);
        repeat (10) @(posedge clock);
        chk({timer_output_pin, timer_pin_select}, 3);
        xfer(`ADDR_TIMER_OUTPUT_MODE, 1'b1, `OUT_FORCE0);
        repeat (10) @(posedge clock);
        chk(timer_output_pin, 0);
        xfer(`ADDR_TIMER_OUTPUT_MODE, 1'b1, 32'h4);
        repeat (3) @(posedge clock);
        chk(timer_pin_select, 0);
        xfer(`ADDR_TIMER_OUTPUT_MODE, 1'b1, `OUT_PWM);
        load(8'hF0);
        repeat (2) begin
            wpin(n);
            if (timer_output_pin === 1'b1) wpin(n);
        end
        wpin(n); chk(n, 2);
        wpin(n); chk(n, 30);
        load(8'h00);
        xfer(`ADDR_FLAGS, 1'b1, 32'h2);
        repeat (5) begin
            xfer(`ADDR_RELOAD_HIGH, 1'b1, 0);
            repeat (100) begin
                @(negedge clock);
                chk(chip_reset_request, 0);
            end
        end
        n = 0;
        while (chip_reset_request !== 1'b1 && n < 700) begin
            @(negedge clock);
            n++;
        end
        chk(n < 700, 1);
        summarize;
    end
endmodule // tb_reload_timer

/* inc/timer_regs.vh */
// register map and constants of the eight-bit reload/watchdog/pwm timer
`ifndef TIMER_REGS_VH
`define TIMER_REGS_VH

// register indices (byte address = index * 4)
`define IDX_TIMER_MODE_PRIMARY 4'hD
`define IDX_RELOAD_LOW 4'hE
`define IDX_RELOAD_HIGH 4'hF
`define IDX_TIMER_OUTPUT_MODE 5'h14
`define IDX_FLAGS 5'h18
`define ADDR_TIMER_MODE_PRIMARY 8'h34
`define ADDR_RELOAD_LOW 8'h38
`define ADDR_RELOAD_HIGH 8'h3C
`define ADDR_TIMER_OUTPUT_MODE 8'h50
`define ADDR_FLAGS 8'h60

// timer_mode_primary fields
`define RELOAD_SELECT_BIT 3
`define CLOCK_SELECT_MSB 2

// flag register fields
`define WATCHDOG_ENABLE_BIT 1
`define OVERFLOW_IRQ_BIT 2

// output modes
`define OUT_PORT 3'h0
`define OUT_TOGGLE 3'h1
`define OUT_FORCE0 3'h2
`define OUT_FORCE1 3'h3
`define OUT_PWM 3'h7

// mode register write spacing in core cycles
`define MODE_WRITE_GAP 2'h2

// prescaler masks per clock select code, tick when all mask bits are set
`define TICK_MASK_SEL0 11'h7FF
`define TICK_MASK_SEL1 11'h3FF
`define TICK_MASK_SEL2 11'h1FF
`define TICK_MASK_SEL3 11'h07F
`define TICK_MASK_SEL4 11'h01F
`define TICK_MASK_SEL5 11'h007
`define TICK_MASK_SEL6 11'h003
`define TICK_MASK_SEL7 11'h001

`define COUNT_MAX 8'hFF
`define PRESCALE_RESET 11'h000

`endif

/* src/reload_timer.v */
// eight-bit reload/watchdog/pwm timer with ahb-lite register slave
`timescale 1ns/1ps
`include "timer_regs.vh"

module reload_timer #(
    parameter PRESCALE_WIDTH = 11
) (
    input wire clock,
    input wire rstn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    output reg timer_output_pin,
    output reg timer_pin_select,
    output reg chip_reset_request,
    output reg overflow_irq_flag
);

    reg [3:0] timer_mode_primary;
    reg [3:0] mode_pending;
    reg mode_pending_valid;
    reg [1:0] mode_gap;
    reg [3:0] reload_value_low_nibble;
    reg [3:0] reload_value_high_nibble;
    reg [3:0] count_low_nibble_latched;
    reg [2:0] timer_output_mode;
    reg watchdog_enable_flag;
    reg [7:0] count;
    reg [PRESCALE_WIDTH-1:0] prescale;
    reg pwm_low_phase;
    reg [PRESCALE_WIDTH-1:0] tick_mask;
    reg dp_write;
    reg dp_read;
    reg [7:0] dp_addr;
    wire [7:0] reload_word;
    wire tick;
    wire overflow;
    wire addr_take;
    wire wr_low;
    wire wr_high;
    wire wr_mode;
    wire wr_outmode;
    wire wr_flags;
    wire rd_high;
    wire [7:0] next_count;

    assign reload_word = {reload_value_high_nibble, reload_value_low_nibble};

    // tick period per clock select
    always @* begin
        case (timer_mode_primary[`CLOCK_SELECT_MSB:0])
            3'h0: tick_mask = `TICK_MASK_SEL0;
            3'h1: tick_mask = `TICK_MASK_SEL1;
            3'h2: tick_mask = `TICK_MASK_SEL2;
            3'h3: tick_mask = `TICK_MASK_SEL3;
            3'h4: tick_mask = `TICK_MASK_SEL4;
            3'h5: tick_mask = `TICK_MASK_SEL5;
            3'h6: tick_mask = `TICK_MASK_SEL6;
            default: tick_mask = `TICK_MASK_SEL7;
        endcase
    end

    assign tick = ((prescale & tick_mask) == tick_mask);
    assign overflow = tick && (count == `COUNT_MAX);

    // ahb-lite address phase
    assign addr_take = hsel && hready && htrans[1];
    assign wr_low = dp_write && (dp_addr == `ADDR_RELOAD_LOW);
    assign wr_high = dp_write && (dp_addr == `ADDR_RELOAD_HIGH);
    assign wr_mode = dp_write && (dp_addr == `ADDR_TIMER_MODE_PRIMARY);
    assign wr_outmode = dp_write && (dp_addr == `ADDR_TIMER_OUTPUT_MODE);
    assign wr_flags = dp_write && (dp_addr == `ADDR_FLAGS);
    assign rd_high = addr_take && !hwrite &&
        (haddr[7:0] == `ADDR_RELOAD_HIGH);

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            dp_write <= 1'b0;
            dp_read <= 1'b0;
            dp_addr <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            dp_write <= addr_take && hwrite;
            dp_read <= addr_take && !hwrite;
            if (addr_take) begin
                dp_addr <= haddr[7:0];
            end
        end
    end

    // read data registered at the address phase, valid in data phase
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            hrdata <= 32'h00000000;
            count_low_nibble_latched <= 4'h0;
        end else if (addr_take && !hwrite) begin
            case (haddr[7:0])
                `ADDR_RELOAD_LOW: hrdata <= {28'h0000000,
                    count_low_nibble_latched};
                `ADDR_RELOAD_HIGH: hrdata <= {28'h0000000, count[7:4]};
                `ADDR_TIMER_OUTPUT_MODE: hrdata <= {29'h00000000,
                    timer_output_mode};
                `ADDR_FLAGS: hrdata <= {29'h00000000, overflow_irq_flag,
                    watchdog_enable_flag, 1'b0};
                default: hrdata <= 32'h00000000;
            endcase
            if (rd_high) begin
                count_low_nibble_latched <= count[3:0];
            end
        end
    end

    // mode register with write spacing
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            timer_mode_primary <= 4'h0;
            mode_pending <= 4'h0;
            mode_pending_valid <= 1'b0;
            mode_gap <= 2'h0;
        end else begin
            if (mode_gap != 2'h0) begin
                mode_gap <= mode_gap - 2'h1;
            end
            if (wr_mode) begin
                mode_pending <= hwdata[3:0];
                mode_pending_valid <= 1'b1;
                mode_gap <= `MODE_WRITE_GAP;
            end else if (mode_pending_valid && mode_gap == 2'h0) begin
                timer_mode_primary <= mode_pending;
                mode_pending_valid <= 1'b0;
            end
        end
    end

    // reload nibbles, output mode, flags
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reload_value_low_nibble <= 4'h0;
            reload_value_high_nibble <= 4'h0;
            timer_output_mode <= 3'h0;
            watchdog_enable_flag <= 1'b0;
            overflow_irq_flag <= 1'b0;
        end else begin
            if (wr_low) begin
                reload_value_low_nibble <= hwdata[3:0];
            end
            if (wr_high) begin
                reload_value_high_nibble <= hwdata[3:0];
            end
            if (wr_outmode) begin
                timer_output_mode <= hwdata[2:0];
            end
            if (wr_flags) begin
                watchdog_enable_flag <= hwdata[`WATCHDOG_ENABLE_BIT];
            end
            // set wins over clear
            if (overflow) begin
                overflow_irq_flag <= 1'b1;
            end else if (wr_flags && !hwdata[`OVERFLOW_IRQ_BIT]) begin
                overflow_irq_flag <= 1'b0;
            end
        end
    end

    assign next_count = timer_mode_primary[`RELOAD_SELECT_BIT] ?
        reload_word : 8'h00;

    // counter and prescaler
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            count <= 8'h00;
            prescale <= `PRESCALE_RESET;
        end else begin
            prescale <= prescale + {{(PRESCALE_WIDTH-1){1'b0}}, 1'b1};
            if (wr_high) begin
                count <= {hwdata[3:0], reload_value_low_nibble};
            end else if (overflow) begin
                count <= next_count;
            end else if (tick) begin
                count <= count + 8'h01;
            end
        end
    end

    // watchdog reset request, one cycle pulse
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            chip_reset_request <= 1'b0;
        end else begin
            chip_reset_request <= overflow && watchdog_enable_flag;
        end
    end

    // timer pin output
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            timer_output_pin <= 1'b0;
            timer_pin_select <= 1'b0;
            pwm_low_phase <= 1'b0;
        end else begin
            timer_pin_select <= (timer_output_mode != `OUT_PORT) &&
                (timer_output_mode == `OUT_TOGGLE ||
                 timer_output_mode == `OUT_FORCE0 ||
                 timer_output_mode == `OUT_FORCE1 ||
                 timer_output_mode == `OUT_PWM);
            case (timer_output_mode)
                `OUT_TOGGLE: begin
                    if (overflow) begin
                        timer_output_pin <= !timer_output_pin;
                    end
                end
                `OUT_FORCE0: begin
                    if (overflow) begin
                        timer_output_pin <= 1'b0;
                    end
                end
                `OUT_FORCE1: begin
                    if (overflow) begin
                        timer_output_pin <= 1'b1;
                    end
                end
                `OUT_PWM: begin
                    // low for one tick span after overflow, then high
                    if (overflow) begin
                        pwm_low_phase <= 1'b1;
                        timer_output_pin <= 1'b0;
                    end else if (tick && pwm_low_phase) begin
                        pwm_low_phase <= 1'b0;
                        timer_output_pin <= 1'b1;
                    end
                end
                default: begin
                    pwm_low_phase <= 1'b0;
                end
            endcase
        end
    end

endmodule // reload_timer
